/* File: src/rofs_relay_select.sv */
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module rofs_relay_select
    import rofs_pkg::*;
#(
    parameter int TQ_UNIT = TQ_UNIT_CYC
)(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    // drive condition inputs, same clock domain
    input  wire rofs_status_s drv,
    input  wire rofs_meas_s   meas,
    // relay contacts, high means closed
    output logic              relay1_contact,
    output logic              relay2_contact,
    output logic              relay3_contact,
    // axi4-lite slave
    input  wire logic [31:0]  s_awaddr,
    input  wire logic         s_awvalid,
    output logic              s_awready,
    input  wire logic [31:0]  s_wdata,
    input  wire logic [3:0]   s_wstrb,
    input  wire logic         s_wvalid,
    output logic              s_wready,
    output logic [1:0]        s_bresp,
    output logic              s_bvalid,
    input  wire logic         s_bready,
    input  wire logic [31:0]  s_araddr,
    input  wire logic         s_arvalid,
    output logic              s_arready,
    output logic [31:0]       s_rdata,
    output logic [1:0]        s_rresp,
    output logic              s_rvalid,
    input  wire logic         s_rready
);
    // refused at elaboration: the prescaler cannot count a unit below one cycle
    if (TQ_UNIT < 1)
    begin : g_unit_check
        $error("TQ_UNIT must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings registers

    logic [CODE_W-1:0]   relay1_function_select;
    logic [CODE_W-1:0]   relay2_function_select;
    logic [CODE_W-1:0]   relay3_function_select;
    logic signed [FW-1:0] agree_level;
    logic [FW-1:0]       agree_width;
    logic [FW-1:0]       min_output_freq;
    logic [FW-1:0]       zero_speed_level;
    logic [TQ_TIME_W-1:0] torque_detect_time;
    logic [2:0]          thru_state;
    logic                run_while_editing_select;

    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_ok;

    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready  = !w_held && !s_bvalid;
    assign do_write  = aw_held && w_held && !s_bvalid;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else if (clk_en)
        begin
            if (s_awvalid && s_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_wvalid && s_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    // out-of-range codes are refused; an unassigned code in range is stored and leaves its relay open
    function automatic logic code_ok(input logic [31:0] d);
        code_ok = (d[31:CODE_W] == '0) && (d[CODE_W-1:0] <= CODE_MAX);
    endfunction : code_ok

    always_comb
    begin
        wr_ok = 1'b1;
        if (aw_addr == OFS_SEL1 || aw_addr == OFS_SEL2 || aw_addr == OFS_SEL3)
            wr_ok = code_ok(w_data) && (w_strb[1:0] == 2'h3);
        else if (aw_addr == OFS_STATUS)
            wr_ok = 1'b0;
        else if (aw_addr > OFS_EDIT || aw_addr[1:0] != 2'h0)
            wr_ok = 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            relay1_function_select   <= DEF_SEL1;
            relay2_function_select   <= DEF_SEL2;
            relay3_function_select   <= DEF_SEL3;
            agree_level              <= '0;
            agree_width              <= '0;
            min_output_freq          <= '0;
            zero_speed_level         <= '0;
            torque_detect_time       <= '0;
            thru_state               <= 3'h0;
            run_while_editing_select <= 1'b0;
        end
        else if (clk_en && do_write && wr_ok)
        begin
            if (aw_addr == OFS_SEL1)
                relay1_function_select <= w_data[CODE_W-1:0];
            else if (aw_addr == OFS_SEL2)
                relay2_function_select <= w_data[CODE_W-1:0];
            else if (aw_addr == OFS_SEL3)
                relay3_function_select <= w_data[CODE_W-1:0];
            else if (aw_addr == OFS_LEVEL && w_strb[1:0] == 2'h3)
                agree_level <= w_data[FW-1:0];
            else if (aw_addr == OFS_WIDTH && w_strb[1:0] == 2'h3)
                agree_width <= w_data[FW-1:0];
            else if (aw_addr == OFS_MINF && w_strb[1:0] == 2'h3)
                min_output_freq <= w_data[FW-1:0];
            else if (aw_addr == OFS_ZLVL && w_strb[1:0] == 2'h3)
                zero_speed_level <= w_data[FW-1:0];
            else if (aw_addr == OFS_TQTIME && w_strb[1:0] == 2'h3)
                torque_detect_time <= w_data[TQ_TIME_W-1:0];
            else if (aw_addr == OFS_THRU && w_strb[0])
                thru_state <= w_data[2:0];
            else if (aw_addr == OFS_EDIT && w_strb[0])
                run_while_editing_select <= w_data[0];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_bvalid <= 1'b0;
            s_bresp  <= 2'h0;
        end
        else if (clk_en)
        begin
            if (do_write)
            begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end
            else if (s_bready)
                s_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive conditions

    logic [FW-1:0] fout_mag;
    logic [FW-1:0] fref_mag;
    logic [FW-1:0] lvl_mag;
    logic [FW:0]   diff_of;
    logic          agree1;
    logic          uagree1;
    logic          fdet1;
    logic          fdet2;
    logic          ready;
    logic          tq_det;
    logic          running;
    logic          undervolt;

    function automatic logic [FW-1:0] mag(input logic signed [FW-1:0] v);
        mag = v[FW-1] ? FW'(-v) : v;
    endfunction : mag

    function automatic logic near(input logic [FW-1:0] a, input logic [FW-1:0] b,
                                  input logic [FW-1:0] w);
        logic [FW:0] d;
        d = (a > b) ? {1'b0, a} - {1'b0, b} : {1'b0, b} - {1'b0, a};
        near = d <= {1'b0, w};
    endfunction : near

    assign fout_mag = mag(meas.out_freq);
    assign fref_mag = mag(meas.ref_freq);
    assign lvl_mag  = mag(agree_level);
    assign diff_of  = {1'b0, lvl_mag} + {1'b0, agree_width};
    assign running  = drv.run_cmd || drv.decel || drv.dc_inject;
    assign agree1   = running && near(fout_mag, fref_mag, agree_width);
    assign uagree1  = near(fout_mag, lvl_mag, agree_width)
                      && near(fref_mag, lvl_mag, agree_width);
    assign undervolt = (meas.bus_volt < meas.uv_trip) || (meas.ctl_volt < meas.uv_trip)
                       || drv.dc_bus_fault;
    assign ready = !drv.fault && !drv.supply_fail && !drv.param_error
                   && !(!running && (drv.over_voltage || drv.under_voltage))
                   && !(drv.editing && !run_while_editing_select);

    // fdet1 holds open from above level+width until below level
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            fdet1 <= 1'b1;
        else if (clk_en)
        begin
            if ({1'b0, fout_mag} > diff_of)
                fdet1 <= 1'b0;
            else if (fout_mag < lvl_mag)
                fdet1 <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            fdet2 <= 1'b0;
        else if (clk_en)
        begin
            if (fout_mag > lvl_mag)
                fdet2 <= 1'b1;
            else if ({1'b0, fout_mag} + {1'b0, agree_width} < {1'b0, lvl_mag})
                fdet2 <= 1'b0;
        end
    end

    // torque must stay beyond threshold longer than the set time
    logic [$clog2(TQ_UNIT+1)-1:0] tq_pre;
    logic [TQ_TIME_W-1:0]         tq_units;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tq_pre   <= '0;
            tq_units <= '0;
            tq_det   <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!drv.torque_beyond)
            begin
                tq_pre   <= '0;
                tq_units <= '0;
                tq_det   <= 1'b0;
            end
            else if (tq_units >= torque_detect_time)
                tq_det <= 1'b1;
            else if (32'(tq_pre) == TQ_UNIT - 1)
            begin
                tq_pre   <= '0;
                tq_units <= tq_units + 1'b1;
            end
            else
                tq_pre <= tq_pre + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // function selection

    function automatic logic known(input logic [7:0] c);
        logic [7:0] k [31];
        logic f;
        k = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0B,
              8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
              8'h1A, 8'h1B, 8'h1E, 8'h20, 8'h2F, 8'h37, 8'h39, 8'h3D, 8'h4C, 8'h4D,
              8'h60};
        f = 1'b0;
        for (int i = 0; i < 31; i++)
            f = f | (k[i] == c);
        known = f;
    endfunction : known

    logic [CODE_W-1:0] sel [3];
    logic [2:0]        next_relay;
    logic [2:0]        relay;

    assign sel[0] = relay1_function_select;
    assign sel[1] = relay2_function_select;
    assign sel[2] = relay3_function_select;

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_relay
            logic       inv;
            logic [7:0] base;
            logic       hit;
            assign inv  = sel[g][8];
            assign base = sel[g][7:0];
            // a process, not a function call, so every condition is in its sensitivity
            always_comb
            begin
                hit = 1'b0;
                case (base)
                    8'h00: hit = running;
                    8'h01: hit = (fout_mag < min_output_freq)
                                 || (fout_mag < zero_speed_level);
                    8'h02: hit = agree1;
                    8'h03: hit = uagree1;
                    8'h04: hit = fdet1;
                    8'h05: hit = fdet2;
                    8'h06: hit = ready;
                    8'h07: hit = undervolt;
                    8'h08: hit = drv.baseblock;
                    8'h0B: hit = tq_det;
                    8'h0C: hit = drv.ref_loss;
                    8'h0E: hit = drv.fault && !drv.cpu_fault_a && !drv.cpu_fault_b;
                    8'h0F: hit = thru_state[g];
                    8'h10: hit = drv.minor_fault;
                    8'h11: hit = drv.reset_term || drv.reset_serial || drv.reset_option;
                    8'h13: hit = agree1;
                    8'h14: hit = uagree1;
                    8'h15: hit = fdet1;
                    8'h16: hit = fdet2;
                    8'h17: hit = !tq_det;
                    8'h1A: hit = drv.reverse && running;
                    8'h1B: hit = !drv.baseblock;
                    8'h1E: hit = drv.restart_try;
                    8'h20: hit = drv.heatsink_overheat_alarm;
                    8'h2F: hit = drv.maintenance;
                    8'h37: hit = running && !drv.baseblock && !drv.dc_inject;
                    8'h39: hit = drv.energy_pulse;
                    8'h3D: hit = drv.speed_search;
                    8'h4C: hit = drv.fast_stop;
                    8'h4D: hit = drv.overheat_limit;
                    8'h60: hit = drv.fan_alarm;
                    default: hit = 1'b0;
                endcase
            end
            // unknown base stays open even when the inverted form is chosen
            assign next_relay[g] = known(base) && (hit ^ inv);
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            relay <= 3'h0;
        else if (clk_en)
            relay <= next_relay;
    end

    assign relay1_contact = relay[0];
    assign relay2_contact = relay[1];
    assign relay3_contact = relay[2];

    ////////////////////////////////////////////////////////////////////////////
    // read channel

    logic [31:0] rd_word;
    logic        rd_ok;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (s_araddr == OFS_SEL1)
            rd_word = 32'(relay1_function_select);
        else if (s_araddr == OFS_SEL2)
            rd_word = 32'(relay2_function_select);
        else if (s_araddr == OFS_SEL3)
            rd_word = 32'(relay3_function_select);
        else if (s_araddr == OFS_LEVEL)
            rd_word = 32'(unsigned'(agree_level));
        else if (s_araddr == OFS_WIDTH)
            rd_word = 32'(agree_width);
        else if (s_araddr == OFS_MINF)
            rd_word = 32'(min_output_freq);
        else if (s_araddr == OFS_ZLVL)
            rd_word = 32'(zero_speed_level);
        else if (s_araddr == OFS_TQTIME)
            rd_word = 32'(torque_detect_time);
        else if (s_araddr == OFS_THRU)
            rd_word = 32'(thru_state);
        else if (s_araddr == OFS_STATUS)
            rd_word = {25'h0, tq_det, fdet2, fdet1, 1'b0, relay};
        else if (s_araddr == OFS_EDIT)
            rd_word = 32'(run_while_editing_select);
        else
            rd_ok = 1'b0;
    end

    assign s_arready = !s_rvalid;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= 2'h0;
        end
        else if (clk_en)
        begin
            if (s_arvalid && s_arready)
            begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_word;
                s_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end
            else if (s_rready)
                s_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    run_relay_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && relay1_function_select == 12'h000 && running |=> relay1_contact)
        else $error("run relay not closed");
    inv_relay_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && relay1_function_select == 12'h108 && $stable(relay1_function_select)
        |=> relay1_contact == !$past(drv.baseblock))
        else $error("inverted relay wrong");
    fault_relay_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && relay1_function_select == 12'h00E && drv.cpu_fault_a
        |=> !relay1_contact)
        else $error("processor fault closed relay");
    fdet_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && {1'b0, fout_mag} > diff_of |=> !fdet1)
        else $error("detection 1 not opened");
    fdet_band_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && fdet2 && fout_mag >= lvl_mag - agree_width && fout_mag <= lvl_mag
        |=> fdet2)
        else $error("detection 2 left band early");
    ready_edit_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && relay1_function_select == 12'h006 && drv.editing
        && !run_while_editing_select |=> !relay1_contact)
        else $error("ready while editing");
    torque_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !drv.torque_beyond |=> !tq_det)
        else $error("torque detect held");
    unknown_open_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && relay1_function_select == 12'h109 |=> !relay1_contact)
        else $error("unassigned code closed relay");
endmodule : rofs_relay_select

/* File: inc/rofs_pkg.sv */
package rofs_pkg;
    localparam int FW = 16;
    localparam int CODE_W = 12;
    localparam logic [CODE_W-1:0] CODE_MAX = 12'h160;
    localparam logic [CODE_W-1:0] INV_FLAG = 12'h100;
    localparam logic [CODE_W-1:0] DEF_SEL1 = 12'h000;
    localparam logic [CODE_W-1:0] DEF_SEL2 = 12'h001;
    localparam logic [CODE_W-1:0] DEF_SEL3 = 12'h002;
    localparam logic [31:0] OFS_SEL1   = 32'h0000_0000;
    localparam logic [31:0] OFS_SEL2   = 32'h0000_0004;
    localparam logic [31:0] OFS_SEL3   = 32'h0000_0008;
    localparam logic [31:0] OFS_LEVEL  = 32'h0000_000C;
    localparam logic [31:0] OFS_WIDTH  = 32'h0000_0010;
    localparam logic [31:0] OFS_MINF   = 32'h0000_0014;
    localparam logic [31:0] OFS_ZLVL   = 32'h0000_0018;
    localparam logic [31:0] OFS_TQTIME = 32'h0000_001C;
    localparam logic [31:0] OFS_THRU   = 32'h0000_0020;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0024;
    localparam logic [31:0] OFS_EDIT   = 32'h0000_0028;
    // torque detect time unit: 1 ms
    localparam int TQ_UNIT_NS = 1000000;
    localparam int CLK_NS = 5;
    localparam int TQ_UNIT_CYC = TQ_UNIT_NS / CLK_NS;
    localparam int TQ_TIME_W = 16;

    typedef struct packed {
        logic          run_cmd;
        logic          decel;
        logic          dc_inject;
        logic          reverse;
        logic          baseblock;
        logic          fault;
        logic          cpu_fault_a;
        logic          cpu_fault_b;
        logic          supply_fail;
        logic          param_error;
        logic          over_voltage;
        logic          under_voltage;
        logic          dc_bus_fault;
        logic          editing;
        logic          torque_beyond;
        logic          ref_loss;
        logic          minor_fault;
        logic          reset_term;
        logic          reset_serial;
        logic          reset_option;
        logic          restart_try;
        logic          heatsink_overheat_alarm;
        logic          maintenance;
        logic          energy_pulse;
        logic          speed_search;
        logic          fast_stop;
        logic          overheat_limit;
        logic          fan_alarm;
    } rofs_status_s;

    typedef struct packed {
        logic signed [FW-1:0] out_freq;
        logic signed [FW-1:0] ref_freq;
        logic        [FW-1:0] bus_volt;
        logic        [FW-1:0] ctl_volt;
        logic        [FW-1:0] uv_trip;
    } rofs_meas_s;
endpackage : rofs_pkg

/* File: test/rofs_plc_model.sv */
`timescale 1ns/10ps
module rofs_plc_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // relay contacts wired to the plc input card
    input  wire logic       relay1_contact,
    input  wire logic       relay2_contact,
    input  wire logic       relay3_contact,
    // contact states as latched by the card
    output logic [2:0]      seen
);
    // the card latches once per clock, so it adds one cycle of delay
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            seen <= 3'h0;
        else
            seen <= {relay3_contact, relay2_contact, relay1_contact};
    end
endmodule : rofs_plc_model

/* File: test/relay_output_function_select_bench.sv */
`timescale 1ns/10ps
module relay_output_function_select_bench
    import rofs_pkg::*;
;
    logic clk = 0, reset_n = 0, clk_en = 1;
    rofs_status_s drv = '0, d;
    rofs_meas_s meas = '0;
    logic r1, r2, r3, awr, wr, bv, arr, rv;
    logic [2:0] seen;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd, awaddr = 0, wdata = 0, araddr = 0;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    int fails = 0, checks = 0, cycles = 0;

    rofs_relay_select #(.TQ_UNIT(4)) dut_u (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .drv(drv), .meas(meas), .relay1_contact(r1), .relay2_contact(r2), .relay3_contact(r3),
        .s_awaddr(awaddr), .s_awvalid(awv), .s_awready(awr), .s_wdata(wdata),
        .s_wstrb(4'hF), .s_wvalid(wv), .s_wready(wr), .s_bresp(bresp), .s_bvalid(bv),
        .s_bready(bre), .s_araddr(araddr), .s_arvalid(arv), .s_arready(arr),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rv), .s_rready(rre));
    rofs_plc_model plc_u (.clk(clk), .reset_n(reset_n), .relay1_contact(r1),
        .relay2_contact(r2), .relay3_contact(r3), .seen(seen));

    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // handshake flags are sampled at the falling edge, where nothing moves
    task axi_write(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
        logic ah, wh, done;
        done = 0;
        @(posedge clk);
        awaddr <= a; wdata <= v; awv <= 1; wv <= 1; bre <= 1;
        while (!done)
        begin
            @(negedge clk);
            ah = awv && awr; wh = wv && wr; done = bv; r = bresp;
            @(posedge clk);
            if (ah) awv <= 0;
            if (wh) wv <= 0;
            if (done) bre <= 0;
        end
    endtask : axi_write
    task axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
        logic done;
        done = 0;
        @(posedge clk);
        araddr <= a; arv <= 1; rre <= 1;
        while (!done)
        begin
            @(negedge clk);
            done = rv; v = rdata; r = rresp;
            if (arv && arr) done = 0;
            @(posedge clk);
            if (arv && arr) arv <= 0;
            if (done) rre <= 0;
        end
    endtask : axi_read
    // relay 1 is judged as the plc card latched it
    task run_code(input logic [11:0] c, input rofs_status_s s, input logic [15:0] f,
                  input logic e);
        axi_write(OFS_SEL1, {20'h0, c}, rs);
        drv <= s; meas.out_freq <= f;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(seen[0], e);
    endtask : run_code
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        axi_read(OFS_SEL1, rd, rs); check(rd, 0);
        axi_read(OFS_SEL2, rd, rs); check(rd, 1);
        axi_read(OFS_SEL3, rd, rs); check(rd, 2);
        axi_write(OFS_SEL2, 32'h161, rs); check(rs, 2);
        axi_read(OFS_SEL2, rd, rs); check(rd, 1);
        axi_read(32'h40, rd, rs); check(rs, 2);
    endtask : t_regs
    task t_run;
        d = '0; run_code(12'h000, d, 0, 0);
        d.run_cmd = 1; run_code(12'h000, d, 0, 1);
        d = '0; d.decel = 1; run_code(12'h000, d, 0, 1);
        d = '0; d.dc_inject = 1; run_code(12'h000, d, 0, 1);
    endtask : t_run
    task t_freq;
        axi_write(OFS_MINF, 100, rs); axi_write(OFS_ZLVL, 100, rs);
        axi_write(OFS_LEVEL, 100, rs); axi_write(OFS_WIDTH, 20, rs);
        d = '0;
        run_code(12'h001, d, 50, 1);
        run_code(12'h001, d, 200, 0);
        run_code(12'h005, d, 110, 1);
        run_code(12'h005, d, 90, 1);
        run_code(12'h005, d, 70, 0);
        run_code(12'h004, d, 130, 0);
        run_code(12'h004, d, 110, 0);
        run_code(12'h004, d, 90, 1);
    endtask : t_freq
    task t_agree;
        @(posedge clk);
        meas.ref_freq <= 100;
        d = '0; d.run_cmd = 1;
        run_code(12'h003, d, 16'hFF9C, 1);
        run_code(12'h003, d, 50, 0);
        check(seen[1], 1);
        run_code(12'h002, d, 110, 1);
        check(seen[2], 1);
        check(seen[1], 0);
        run_code(12'h002, d, 130, 0);
        check(seen[2], 0);
        d.editing = 1; run_code(12'h006, d, 0, 0);
        axi_write(OFS_EDIT, 1, rs); run_code(12'h006, d, 0, 1);
        d = '0; d.under_voltage = 1; run_code(12'h006, d, 0, 0);
    endtask : t_agree
    task t_flags;
        d = '0; d.baseblock = 1; run_code(12'h008, d, 0, 1);
        run_code(12'h108, d, 0, 0);
        d = '0; run_code(12'h108, d, 0, 1);
        d.dc_bus_fault = 1; run_code(12'h007, d, 0, 1);
        d = '0; d.fault = 1; run_code(12'h00E, d, 0, 1);
        d.cpu_fault_a = 1; run_code(12'h00E, d, 0, 0);
        d = '0; d.ref_loss = 1; run_code(12'h00C, d, 0, 1);
        d = '0; d.minor_fault = 1; run_code(12'h010, d, 0, 1);
        d = '0; d.reset_serial = 1; run_code(12'h011, d, 0, 1);
        d = '0; d.fan_alarm = 1; run_code(12'h060, d, 0, 1);
        d = '0; d.reverse = 1; d.run_cmd = 1; run_code(12'h01A, d, 0, 1);
        d = '0; run_code(12'h11B, d, 0, 0);
        d = '1; run_code(12'h009, d, 0, 0);
        d = '0; run_code(12'h109, d, 0, 0);
        axi_write(OFS_THRU, 1, rs); run_code(12'h00F, d, 0, 1);
        axi_read(OFS_STATUS, rd, rs); check(rd[0], 1);
        axi_write(OFS_THRU, 0, rs); run_code(12'h00F, d, 0, 0);
    endtask : t_flags
    task t_torque;
        axi_write(OFS_TQTIME, 2, rs);
        d = '0; d.torque_beyond = 1;
        run_code(12'h00B, d, 0, 0);
        repeat (30) @(posedge clk);
        @(negedge clk);
        check(seen[0], 1);
        run_code(12'h017, d, 0, 0);
    endtask : t_torque
    task wrap_up;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        meas.bus_volt = 100; meas.ctl_volt = 100; meas.uv_trip = 50;
        repeat (3) @(posedge clk);
        reset_n <= 1;
        t_regs();
        t_run();
        t_freq();
        t_agree();
        t_flags();
        t_torque();
        wrap_up();
    end
endmodule : relay_output_function_select_bench
